// [rtl/spb_slot_regs.v]
// slot b power control and status registers with smbus slave access
//
// What this block does
// - control bit7 reads aux power good
// - control bit6 reads main power good
// - control bit2 set makes power good ignore override pin
// - control bit1 is main power enable
// - control bit0 is aux power enable
// - control register resets to zero
// - power good pin needs both good flags
// - override low, gate zero forces not-good
// - good flags ignore override input
// - status bit7 shows fault condition latched
// - status bit6 shows main outputs on
// - status bit5 shows aux output on
// - overcurrent flags set per supply
// - writing one clears flag and interrupt
// - reads and clears leave fault pin
// - fault latch released by enable input low
// - register power control keeps fault inactive
// - override low releases fault pin
// - fault flag ignores override input
// - status register resets to zero
`include "spb_regs.vh"

module spb_slot_regs (
   input wire sys_clk_in,
   input wire rst_in,
   input wire smb_scl_in,
   input wire smb_sda_in,
   output reg smb_sda_o_out,
   output reg smb_sda_oe_out,
   input wire aux_pg_in,
   input wire main_pg_in,
   input wire override_input_pin_n_in,
   input wire main_on_input_in,
   input wire aux_on_input_in,
   input wire aux_oc_in,
   input wire high_oc_in,
   input wire low_oc_in,
   output reg main_power_out,
   output reg aux_power_out,
   output reg power_good_pin_oe_out,
   output reg fault_output_pin_oe_out,
   output reg int_out
);

   // ============================================================
   // input synchronisers
   localparam NSYNC = 10;
   localparam [NSYNC-1:0] SYNC_IDLE = `SPB_SYNC_IDLE;
   wire [NSYNC-1:0] raw_w;
   reg [NSYNC-1:0] sync1_r;
   reg [NSYNC-1:0] sync2_r;
   assign raw_w = {smb_scl_in, smb_sda_in, aux_pg_in, main_pg_in,
                   override_input_pin_n_in, main_on_input_in,
                   aux_on_input_in, aux_oc_in, high_oc_in, low_oc_in};
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
         always @(posedge sys_clk_in or posedge rst_in) begin
            if (rst_in) begin
               sync1_r[gi] <= SYNC_IDLE[gi];
               sync2_r[gi] <= SYNC_IDLE[gi];
            end else begin
               sync1_r[gi] <= raw_w[gi];
               sync2_r[gi] <= sync1_r[gi];
            end
         end
      end
   endgenerate

   wire scl_s = sync2_r[9];
   wire sda_s = sync2_r[8];
   wire aux_pg_s = sync2_r[7];
   wire main_pg_s = sync2_r[6];
   wire override_n_s = sync2_r[5];
   wire main_on_s = sync2_r[4];
   wire aux_on_s = sync2_r[3];
   wire aux_oc_s = sync2_r[2];
   wire high_oc_s = sync2_r[1];
   wire low_oc_s = sync2_r[0];

   // ============================================================
   // bus condition detection
   reg scl_d_r;
   reg sda_d_r;
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end else begin
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   wire scl_rise = scl_s & ~scl_d_r;
   wire scl_fall = ~scl_s & scl_d_r;
   wire start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire stop_det = scl_s & scl_d_r & ~sda_d_r & sda_s;

   // ============================================================
   // register state
   reg [2:0] ctrl_r;
   reg aux_oc_flag_r;
   reg high_oc_flag_r;
   reg low_oc_flag_r;
   reg main_latch_r;
   reg aux_latch_r;
   reg wr_stb_r;
   reg [7:0] wr_data_r;
   reg [7:0] cmd_r;

   wire wr_ctrl = wr_stb_r & (cmd_r == `SPB_CMD_CONTROL);
   wire wr_stat = wr_stb_r & (cmd_r == `SPB_CMD_STATUS);
   wire reg_mode = ctrl_r[`SPB_CTL_MAIN_EN] | ctrl_r[`SPB_CTL_AUX_EN];
   wire fault_cond = main_latch_r | aux_latch_r;
   wire main_act = ctrl_r[`SPB_CTL_MAIN_EN] | (main_on_s & ~main_latch_r);
   wire aux_act = ctrl_r[`SPB_CTL_AUX_EN] | (aux_on_s & ~aux_latch_r);

   // ============================================================
   // readback images
   wire [7:0] ctrl_img;
   wire [7:0] stat_img;
   reg [7:0] rd_data;
   assign ctrl_img = {aux_pg_s, main_pg_s, 3'h0, ctrl_r};
   assign stat_img = {fault_cond, main_act, aux_act, aux_oc_flag_r, 1'b0,
                      high_oc_flag_r, 1'b0, low_oc_flag_r};
   always @* begin
      rd_data = 8'h00;
      if (cmd_r == `SPB_CMD_CONTROL)
         rd_data = ctrl_img;
      else if (cmd_r == `SPB_CMD_STATUS)
         rd_data = stat_img;
   end

   // ============================================================
   // control register
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ctrl_r <= `SPB_CONTROL_RST;
      end else if (wr_ctrl) begin
         ctrl_r <= wr_data_r[2:0];
      end
   end

   // ============================================================
   // overcurrent flags
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         aux_oc_flag_r <= 1'b0;
         high_oc_flag_r <= 1'b0;
         low_oc_flag_r <= 1'b0;
      end else begin
         if (aux_oc_s)
            aux_oc_flag_r <= 1'b1;
         else if (wr_stat & wr_data_r[`SPB_STA_AUX_OC])
            aux_oc_flag_r <= 1'b0;
         if (high_oc_s)
            high_oc_flag_r <= 1'b1;
         else if (wr_stat & wr_data_r[`SPB_STA_HIGH_OC])
            high_oc_flag_r <= 1'b0;
         if (low_oc_s)
            low_oc_flag_r <= 1'b1;
         else if (wr_stat & wr_data_r[`SPB_STA_LOW_OC])
            low_oc_flag_r <= 1'b0;
      end
   end

   // ============================================================
   // fault latches, independent of status register access
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         main_latch_r <= 1'b0;
         aux_latch_r <= 1'b0;
      end else if (reg_mode) begin
         // no fault reporting under register control
         main_latch_r <= 1'b0;
         aux_latch_r <= 1'b0;
      end else begin
         // release only by the cause's enable low
         // status reads and clears not involved
         if (!main_on_s)
            main_latch_r <= 1'b0;
         else if (high_oc_s | low_oc_s)
            main_latch_r <= 1'b1;
         if (!aux_on_s)
            aux_latch_r <= 1'b0;
         else if (aux_oc_s)
            aux_latch_r <= 1'b1;
      end
   end

   // ============================================================
   // pin outputs
   wire override_act = ~override_n_s;
   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         main_power_out <= 1'b0;
         aux_power_out <= 1'b0;
         power_good_pin_oe_out <= 1'b0;
         fault_output_pin_oe_out <= 1'b0;
         int_out <= 1'b0;
      end else begin
         main_power_out <= main_act;
         aux_power_out <= aux_act;
         // good needs both flags, override forces not-good unless gate bit set
         power_good_pin_oe_out <= aux_pg_s & main_pg_s &
            ~(override_act & ~ctrl_r[`SPB_CTL_GATE]);
         fault_output_pin_oe_out <= fault_cond & ~override_act;
         int_out <= aux_oc_flag_r | high_oc_flag_r | low_oc_flag_r;
      end
   end

   // ============================================================
   // smbus slave: write byte, read byte, receive byte
   localparam ST_IDLE = 4'h0;
   localparam ST_ADDR = 4'h1;
   localparam ST_ACK_A = 4'h2;
   localparam ST_CMD = 4'h3;
   localparam ST_ACK_C = 4'h4;
   localparam ST_WDATA = 4'h5;
   localparam ST_RDATA = 4'h6;
   localparam ST_RACK = 4'h7;

   reg [3:0] st_r;
   reg [3:0] cnt_r;
   reg [7:0] sh_r;
   reg rw_r;
   reg nack_r;
   reg is_data_r;

   always @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         st_r <= ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         nack_r <= 1'b0;
         is_data_r <= 1'b0;
         cmd_r <= 8'h00;
         wr_stb_r <= 1'b0;
         wr_data_r <= 8'h00;
         smb_sda_o_out <= 1'b0;
         smb_sda_oe_out <= 1'b0;
      end else begin
         wr_stb_r <= 1'b0;
         if (start_det) begin
            st_r <= ST_ADDR;
            cnt_r <= 4'h0;
            smb_sda_oe_out <= 1'b0;
         end else if (stop_det) begin
            st_r <= ST_IDLE;
            smb_sda_oe_out <= 1'b0;
         end else if (scl_rise) begin
            case (st_r)
               ST_ADDR, ST_CMD, ST_WDATA: begin
                  sh_r <= {sh_r[6:0], sda_s};
                  cnt_r <= cnt_r + 4'h1;
               end
               ST_RDATA: begin
                  cnt_r <= cnt_r + 4'h1;
               end
               ST_RACK: begin
                  nack_r <= sda_s;
               end
               default: begin
                  cnt_r <= cnt_r;
               end
            endcase
         end else if (scl_fall) begin
            case (st_r)
               ST_ADDR: begin
                  if (cnt_r == `SPB_BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     if (sh_r[7:1] == `SPB_SLAVE_ADDR) begin
                        rw_r <= sh_r[0];
                        smb_sda_oe_out <= 1'b1;
                        st_r <= ST_ACK_A;
                     end else begin
                        st_r <= ST_IDLE;
                     end
                  end
               end
               ST_ACK_A: begin
                  if (rw_r) begin
                     sh_r <= rd_data;
                     smb_sda_oe_out <= ~rd_data[7];
                     st_r <= ST_RDATA;
                  end else begin
                     smb_sda_oe_out <= 1'b0;
                     is_data_r <= 1'b0;
                     st_r <= ST_CMD;
                  end
               end
               ST_CMD, ST_WDATA: begin
                  if (cnt_r == `SPB_BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     smb_sda_oe_out <= 1'b1;
                     st_r <= ST_ACK_C;
                     if (st_r == ST_CMD) begin
                        cmd_r <= sh_r;
                     end else begin
                        wr_data_r <= sh_r;
                        wr_stb_r <= 1'b1;
                     end
                  end
               end
               ST_ACK_C: begin
                  smb_sda_oe_out <= 1'b0;
                  st_r <= ST_WDATA;
               end
               ST_RDATA: begin
                  if (cnt_r == `SPB_BYTE_BITS) begin
                     cnt_r <= 4'h0;
                     smb_sda_oe_out <= 1'b0;
                     st_r <= ST_RACK;
                  end else begin
                     sh_r <= {sh_r[6:0], 1'b0};
                     smb_sda_oe_out <= ~sh_r[6];
                  end
               end
               ST_RACK: begin
                  if (nack_r) begin
                     st_r <= ST_IDLE;
                  end else begin
                     sh_r <= rd_data;
                     smb_sda_oe_out <= ~rd_data[7];
                     st_r <= ST_RDATA;
                  end
               end
               default: begin
                  st_r <= ST_IDLE;
               end
            endcase
         end
      end
   end

endmodule

// [inc/spb_regs.vh]
// register map, field positions and reset values of the slot b bank
`ifndef SPB_REGS_VH
`define SPB_REGS_VH

// ============================================================
// command bytes (register selectors)
`define SPB_CMD_CONTROL 8'h03
`define SPB_CMD_STATUS 8'h05

// ============================================================
// reset values
`define SPB_CONTROL_RST 3'h0
`define SPB_STATUS_RST 8'h00
// idle pin levels held by the synchronisers in reset:
// scl, sda and the active-low override input sit high
`define SPB_SYNC_IDLE 10'h320

// ============================================================
// control register fields
`define SPB_CTL_AUX_PG 7
`define SPB_CTL_MAIN_PG 6
`define SPB_CTL_GATE 2
`define SPB_CTL_MAIN_EN 1
`define SPB_CTL_AUX_EN 0

// ============================================================
// status register fields
`define SPB_STA_FAULT 7
`define SPB_STA_MAIN_ON 6
`define SPB_STA_AUX_ON 5
`define SPB_STA_AUX_OC 4
`define SPB_STA_HIGH_OC 2
`define SPB_STA_LOW_OC 0

// ============================================================
// serial link constants
`define SPB_SLAVE_ADDR 7'h47
`define SPB_BYTE_BITS 4'h8

`endif

// [tb/spb_slot_regs_properties.sv]
// checker of pin relations for the slot b register bank
module spb_slot_regs_properties (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic smb_scl_in,
   input wire logic aux_pg_in,
   input wire logic main_pg_in,
   input wire logic override_input_pin_n_in,
   input wire logic main_on_input_in,
   input wire logic aux_on_input_in,
   input wire logic aux_oc_in,
   input wire logic high_oc_in,
   input wire logic low_oc_in,
   input wire logic power_good_pin_oe_out,
   input wire logic fault_output_pin_oe_out,
   input wire logic int_out
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   // ============================================================
   // assertions
   pg_low_a: assert property (
      (!aux_pg_in || !main_pg_in) [*5] |-> !power_good_pin_oe_out)
      else $error("power good without supplies");
   pg_high_a: assert property (
      (aux_pg_in && main_pg_in && override_input_pin_n_in) [*5]
      |-> power_good_pin_oe_out) else $error("power good missing");
   ovr_fault_a: assert property (
      (!override_input_pin_n_in) [*5] |-> !fault_output_pin_oe_out)
      else $error("fault pin held under override");
   off_fault_a: assert property (
      (!main_on_input_in && !aux_on_input_in) [*5]
      |-> !fault_output_pin_oe_out) else $error("fault pin not released");
   oc_quiet_a: assert property (
      (!aux_oc_in && !high_oc_in && !low_oc_in) [*5] |-> !$rose(int_out))
      else $error("interrupt without overcurrent");
   int_set_a: assert property (
      (aux_oc_in || high_oc_in || low_oc_in) [*3] |-> ##[1:4] int_out)
      else $error("overcurrent flag not raised");
   int_fall_a: assert property (
      $fell(int_out) |-> !smb_scl_in) else $error("interrupt dropped early");
   reset_out_a: assert property (
      $fell(rst_in) |-> !int_out && !fault_output_pin_oe_out)
      else $error("outputs active after reset");
endmodule

bind spb_slot_regs spb_slot_regs_properties chk (
   .sys_clk_in(sys_clk_in),
   .rst_in(rst_in),
   .smb_scl_in(smb_scl_in),
   .aux_pg_in(aux_pg_in),
   .main_pg_in(main_pg_in),
   .override_input_pin_n_in(override_input_pin_n_in),
   .main_on_input_in(main_on_input_in),
   .aux_on_input_in(aux_on_input_in),
   .aux_oc_in(aux_oc_in),
   .high_oc_in(high_oc_in),
   .low_oc_in(low_oc_in),
   .power_good_pin_oe_out(power_good_pin_oe_out),
   .fault_output_pin_oe_out(fault_output_pin_oe_out),
   .int_out(int_out));

// [tb/spb_host_model.sv]
// smbus host model on an open-drain data wire
`include "spb_regs.vh"
module spb_host_model (
   input wire logic sys_clk_in,
   input wire logic dev_oe_in,
   output logic scl_out,
   output wire logic sda_out
);
   timeunit 1ns;
   timeprecision 100ps;
   logic pull_r = 1'b0;
   // pull-up: a released wire reads high
   assign sda_out = !(pull_r || dev_oe_in);
   initial scl_out = 1'b1;
   task automatic hp();
      repeat (4) @(posedge sys_clk_in);
   endtask
   task automatic start();
      pull_r <= 1'b0;
      hp();
      scl_out <= 1'b1;
      hp();
      pull_r <= 1'b1;
      hp();
      scl_out <= 1'b0;
      hp();
   endtask
   task automatic stop();
      pull_r <= 1'b1;
      hp();
      scl_out <= 1'b1;
      hp();
      pull_r <= 1'b0;
      hp();
   endtask
   task automatic bit_io(input logic b, output logic s);
      pull_r <= !b;
      hp();
      scl_out <= 1'b1;
      hp();
      s = sda_out;
      scl_out <= 1'b0;
      hp();
   endtask
   // msb first, ninth bit is the acknowledge
   task automatic xfer(input logic [7:0] d, output logic [7:0] q,
                       output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
         q[i] = s;
      end
      bit_io(1'b1, ack);
   endtask
   task automatic wr(input logic [7:0] c, d, output logic nak);
      logic [7:0] q;
      logic a0, a1, a2;
      start();
      xfer({`SPB_SLAVE_ADDR, 1'b0}, q, a0);
      xfer(c, q, a1);
      xfer(d, q, a2);
      stop();
      nak = a0 | a1 | a2;
   endtask
   task automatic rd(input logic [7:0] c, output logic [7:0] d);
      logic [7:0] q;
      logic a;
      start();
      xfer({`SPB_SLAVE_ADDR, 1'b0}, q, a);
      xfer(c, q, a);
      start();
      xfer({`SPB_SLAVE_ADDR, 1'b1}, q, a);
      xfer(8'hff, d, a);
      stop();
   endtask
endmodule

// [tb/tb.sv]
// self-checking bench for the slot b register bank
`include "spb_regs.vh"
module tb;
   timeunit 1ns;
   timeprecision 100ps;
   logic sys_clk, rst, apg, mpg, ovr_n, mon, aon, aoc, hoc, loc;
   wire scl, sda, sda_o, sda_oe, mpw, apw, pg_oe, flt_oe, intr;
   integer failures = 0, cmp_count = 0, seed = 32'h6349;
   logic [2:0] ctl;
   logic [7:0] fl, q, d;
   logic ml, al, nak;
   spb_host_model host (.sys_clk_in(sys_clk), .dev_oe_in(sda_oe),
      .scl_out(scl), .sda_out(sda));
   spb_slot_regs uut (.sys_clk_in(sys_clk), .rst_in(rst),
      .smb_scl_in(scl), .smb_sda_in(sda), .smb_sda_o_out(sda_o),
      .smb_sda_oe_out(sda_oe), .aux_pg_in(apg), .main_pg_in(mpg),
      .override_input_pin_n_in(ovr_n), .main_on_input_in(mon),
      .aux_on_input_in(aon), .aux_oc_in(aoc), .high_oc_in(hoc),
      .low_oc_in(loc), .main_power_out(mpw), .aux_power_out(apw),
      .power_good_pin_oe_out(pg_oe), .fault_output_pin_oe_out(flt_oe),
      .int_out(intr));
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   task automatic chk(input string nm, input logic [7:0] seen, exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic upd();
      if (aoc) fl[4] = 1'b1;
      if (hoc) fl[2] = 1'b1;
      if (loc) fl[0] = 1'b1;
      if (ctl[1:0] != 2'b00 || !mon) ml = 1'b0;
      else if (hoc || loc) ml = 1'b1;
      if (ctl[1:0] != 2'b00 || !aon) al = 1'b0;
      else if (aoc) al = 1'b1;
   endtask
   task automatic settle();
      repeat (8) @(posedge sys_clk);
      upd();
   endtask
   task automatic hwr(input logic [7:0] c, v);
      // on inputs low before register mode
      if (c == `SPB_CMD_CONTROL && v[1:0] != 2'b00) {mon, aon} <= 2'b00;
      host.wr(c, v, nak);
      chk("ack", {7'h00, nak}, 8'h00);
      if (c == `SPB_CMD_CONTROL) ctl = v[2:0];
      if (c == `SPB_CMD_STATUS) fl = fl & ~(v & 8'h15);
      settle();
   endtask
   task automatic step();
      logic [31:0] r;
      r = $random(seed);
      {apg, mpg} <= r[1:0];
      ovr_n <= r[2] | r[3];
      // on inputs low in register mode
      mon <= r[4] & (ctl[1:0] == 2'b00);
      aon <= r[5] & (ctl[1:0] == 2'b00);
      {aoc, hoc, loc} <= {&r[8:6], &r[11:9], &r[14:12]};
      settle();
      {aoc, hoc, loc} <= 3'b000;
      settle();
   endtask
   task automatic check_all();
      logic [7:0] e;
      host.rd(`SPB_CMD_CONTROL, q);
      chk("control", q, {apg, mpg, 3'b000, ctl});
      e = {ml | al, ctl[1] | (mon & !ml), ctl[0] | (aon & !al),
           fl[4], 1'b0, fl[2], 1'b0, fl[0]};
      host.rd(`SPB_CMD_STATUS, q);
      chk("status", q, e);
      chk("pins", {2'b00, sda_o, mpw, apw, pg_oe, flt_oe, intr},
          {3'b000, e[6:5],
          apg & mpg & (ovr_n | ctl[2]), e[7] & ovr_n, |fl});
   endtask
   initial begin
      rst <= 1'b1;
      {apg, mpg, mon, aon, aoc, hoc, loc} <= 7'h00;
      ovr_n <= 1'b1;
      {ctl, fl, ml, al} = 13'h0000;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      settle();
      check_all();
      hwr(8'h07, 8'hff);
      host.rd(8'h07, q);
      chk("unmapped", q, 8'h00);
      hwr(`SPB_CMD_CONTROL, 8'hf8);
      check_all();
      $display("directed test done");
      repeat (40) begin
         d = $random(seed);
         if (d[7]) d[1:0] = 2'b00;
         hwr(d[6] ? `SPB_CMD_CONTROL : `SPB_CMD_STATUS, d);
         step();
         check_all();
      end
      $display("random test done");
      rst <= 1'b1;
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      {ctl, fl, ml, al} = 13'h0000;
      settle();
      check_all();
      $display("reset test done");
      conclude();
   end
   initial begin
      repeat (90000) @(posedge sys_clk);
      failures++;
      conclude();
   end
endmodule
